//--- hdl/aor_readout.sv
`timescale 1ns/1ps
module aor_readout (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Register access from the serial interface engine.
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        xfer_active_i,
  output logic      [7:0]  reg_rdata_o,
  // Measurement front end.
  input  wire logic        meas_done_i,
  input  wire logic [11:0] x_accel_i,
  input  wire logic [11:0] y_accel_i,
  input  wire logic [11:0] z_accel_i,
  input  wire logic [7:0]  temp_i,
  input  wire logic        calib_done_i,
  input  wire logic [1:0]  orient_debounce_count_i,
  input  wire logic [3:0]  shake_event_i,
  input  wire logic [7:0]  src0_clear_i,
  input  wire logic        new_sample_clear_i,
  // Status and interrupt pin.
  output logic      [1:0]  xy_orient_filtered_o,
  output logic      [1:0]  z_orient_filtered_o,
  output logic             new_sample_flag_o,
  output logic             soft_reset_active_o,
  output logic             irq_pin_o,
  output logic             irq_oe_n_o
);
  import aor_pkg::*;

  // ----------------------------------------------------------------
  // Soft reset
  // ----------------------------------------------------------------
  logic soft_rst_hold;
  logic core_rst;
  logic soft_rst_req;

  assign soft_rst_req = reg_wr_i && (reg_addr_i == ADDR_SRC1) &&
                        reg_wdata_i[SOFT_RESET_BIT];
  assign core_rst     = rst_i || soft_rst_hold;

  // The hold itself sits on the power-up reset only, like the bus engine.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      soft_rst_hold <= 1'b0;
    end else if (soft_rst_req) begin
      soft_rst_hold <= 1'b1;
    end else if (!xfer_active_i) begin
      soft_rst_hold <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  logic [11:0] x_accel_result;
  logic [11:0] y_accel_result;
  logic [11:0] z_accel_result;
  logic [7:0]  temperature_result;
  logic        sample_strobe;

  // One strobe loads every axis and temperature in the same edge.
  always_ff @(posedge sys_clk_i) begin
    if (core_rst) begin
      x_accel_result     <= ACCEL_RESET;
      y_accel_result     <= ACCEL_RESET;
      z_accel_result     <= ACCEL_RESET;
      temperature_result <= TEMP_RESET;
      sample_strobe      <= 1'b0;
    end else begin
      sample_strobe <= meas_done_i;
      if (meas_done_i) begin
        x_accel_result     <= x_accel_i;
        y_accel_result     <= y_accel_i;
        z_accel_result     <= z_accel_i;
        temperature_result <= temp_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Instantaneous orientation
  // ----------------------------------------------------------------
  logic [11:0] x_mag;
  logic [11:0] y_mag;
  logic        x_larger;
  logic        xy_tilted;
  logic [1:0]  xy_orient_instant;
  logic [1:0]  z_orient_instant;

  assign x_mag    = x_accel_result[11] ? 12'(-x_accel_result) : x_accel_result;
  assign y_mag    = y_accel_result[11] ? 12'(-y_accel_result) : y_accel_result;
  assign x_larger = x_mag >= y_mag;
  // The larger magnitude must pass the limit for a valid XY decision.
  assign xy_tilted = x_larger ? (x_mag <= XY_VALID_MIN) : (y_mag <= XY_VALID_MIN);
  assign xy_orient_instant = x_larger ? (x_accel_result[11] ? XY_NEG_X : XY_POS_X) :
                                        (y_accel_result[11] ? XY_NEG_Y : XY_POS_Y);
  // Horizontal Z reads tilt clear; large tilt reports up or down by sign.
  assign z_orient_instant = {xy_tilted, z_accel_result[11]};

  // ----------------------------------------------------------------
  // Filtered orientation
  // ----------------------------------------------------------------
  logic [1:0] xy_orient_filtered;
  logic [1:0] z_orient_filtered;
  logic       xy_change;
  logic       z_change;

  aor_orient_filter u_filter (
    .sys_clk_i               (sys_clk_i),
    .rst_i                   (core_rst),
    .sample_i                (sample_strobe),
    .orient_debounce_count_i (orient_debounce_count_i),
    .xy_instant_i            (xy_orient_instant),
    .z_instant_i             (z_orient_instant),
    .xy_filtered_o           (xy_orient_filtered),
    .z_filtered_o            (z_orient_filtered),
    .xy_change_o             (xy_change),
    .z_change_o              (z_change)
  );

  // ----------------------------------------------------------------
  // Flags and enables
  // ----------------------------------------------------------------
  logic       new_sample_flag;
  logic       calib_loaded_flag;
  logic [7:0] src0;
  logic [7:0] shake_orient_irq_enable;
  logic [7:0] src0_set;
  logic [7:0] next_src0;

  assign src0_set  = {z_change, xy_change, 2'b00, shake_event_i};
  // A set in the clearing cycle wins over the clear.
  assign next_src0 = (src0 & ~src0_clear_i) | src0_set;

  always_ff @(posedge sys_clk_i) begin
    if (core_rst) begin
      new_sample_flag         <= 1'b0;
      calib_loaded_flag       <= 1'b0;
      src0                    <= 8'h00;
      shake_orient_irq_enable <= IRQ_EN_RESET;
    end else begin
      src0 <= next_src0;
      if (sample_strobe) begin
        new_sample_flag <= 1'b1;
      end else if (new_sample_clear_i) begin
        new_sample_flag <= 1'b0;
      end
      if (calib_done_i) begin
        calib_loaded_flag <= 1'b1;
      end
      if (reg_wr_i && (reg_addr_i == ADDR_IRQ_EN)) begin
        shake_orient_irq_enable <= reg_wdata_i & 8'hcf;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] src1_value;
  logic [7:0] status_value;
  logic [7:0] read_value;
  logic       irq_any;

  assign src1_value   = {z_orient_filtered, xy_orient_filtered, 3'b000, new_sample_flag};
  assign status_value = {3'b000, calib_loaded_flag, z_orient_instant,
                         xy_orient_instant};

  assign read_value =
    (reg_addr_i == ADDR_SRC0)   ? src0 :
    (reg_addr_i == ADDR_SRC1)   ? src1_value :
    (reg_addr_i == ADDR_STATUS) ? status_value :
    (reg_addr_i == ADDR_X_HIGH) ? x_accel_result[11:4] :
    (reg_addr_i == ADDR_X_LOW)  ? {x_accel_result[3:0], 4'h0} :
    (reg_addr_i == ADDR_Y_HIGH) ? y_accel_result[11:4] :
    (reg_addr_i == ADDR_Y_LOW)  ? {y_accel_result[3:0], 4'h0} :
    (reg_addr_i == ADDR_Z_HIGH) ? z_accel_result[11:4] :
    (reg_addr_i == ADDR_Z_LOW)  ? {z_accel_result[3:0], 4'h0} :
    (reg_addr_i == ADDR_TEMP)   ? temperature_result :
                                  8'h00;

  assign irq_any = |(next_src0 & shake_orient_irq_enable);

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= read_value;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (core_rst) begin
      xy_orient_filtered_o <= ORIENT_RESET;
      z_orient_filtered_o  <= ORIENT_RESET;
      new_sample_flag_o    <= 1'b0;
      irq_pin_o            <= 1'b0;
      irq_oe_n_o           <= 1'b1;
    end else begin
      xy_orient_filtered_o <= xy_orient_filtered;
      z_orient_filtered_o  <= z_orient_filtered;
      new_sample_flag_o    <= new_sample_flag;
      irq_pin_o            <= 1'b0;
      irq_oe_n_o           <= !irq_any;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      soft_reset_active_o <= 1'b0;
    end else begin
      soft_reset_active_o <= soft_rst_hold || soft_rst_req;
    end
  end
endmodule // aor_readout

//--- hdl/aor_pkg.sv
// How it works
// - Small tilt: XY keeps updating, Z horizontal.
// - Large tilt: Z up/down from Z sign.
// - Filtered Z upper bit is tilt flag.
// - Tilt set freezes filtered XY orientation.
// - Filtered fields change after consecutive valid readings.
// - Count code selects 16, 32, 64, 128.
// - New sample flag set per measurement.
// - Soft reset bit resets all but bus.
// - Soft reset held while transfer active.
// - Status 0x02: instant XY, Z, calibration flag, zeros.
// - Calibration flag sets once, cleared only by reset or soft reset.
// - X result split into 0x03, 0x04.
// - Y result split into 0x05, 0x06.
// - Z result split into 0x07, 0x08.
// - Temperature result at 0x09.
// - Write-only enable register at 0x0A.
// - Interrupt low: NOR of enabled sources.
package aor_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SRC0    = 8'h00;
  localparam logic [7:0] ADDR_SRC1    = 8'h01;
  localparam logic [7:0] ADDR_STATUS  = 8'h02;
  localparam logic [7:0] ADDR_X_HIGH  = 8'h03;
  localparam logic [7:0] ADDR_X_LOW   = 8'h04;
  localparam logic [7:0] ADDR_Y_HIGH  = 8'h05;
  localparam logic [7:0] ADDR_Y_LOW   = 8'h06;
  localparam logic [7:0] ADDR_Z_HIGH  = 8'h07;
  localparam logic [7:0] ADDR_Z_LOW   = 8'h08;
  localparam logic [7:0] ADDR_TEMP    = 8'h09;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h0a;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SOFT_RESET_BIT    = 4;
  localparam int NEW_SAMPLE_BIT    = 0;
  localparam int Z_CHANGE_BIT      = 7;
  localparam int XY_CHANGE_BIT     = 6;
  localparam int CALIB_LOADED_BIT  = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  IRQ_EN_RESET  = 8'h00;
  localparam logic [11:0] ACCEL_RESET   = 12'h000;
  localparam logic [7:0]  TEMP_RESET    = 8'h00;
  localparam logic [1:0]  ORIENT_RESET  = 2'h0;

  // ----------------------------------------------------------------
  // Orientation encodings and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] XY_POS_X = 2'h0;
  localparam logic [1:0] XY_POS_Y = 2'h1;
  localparam logic [1:0] XY_NEG_X = 2'h2;
  localparam logic [1:0] XY_NEG_Y = 2'h3;

  // The larger magnitude of X and Y must exceed this for a valid XY decision: 0.375 g at 1024 counts/g.
  localparam logic [11:0] XY_VALID_MIN = 12'h180;

  localparam logic [7:0] ORIENT_COUNT_00 = 8'h10;
  localparam logic [7:0] ORIENT_COUNT_01 = 8'h20;
  localparam logic [7:0] ORIENT_COUNT_10 = 8'h40;
  localparam logic [7:0] ORIENT_COUNT_11 = 8'h80;

endpackage

//--- hdl/aor_orient_filter.sv
`timescale 1ns/1ps
module aor_orient_filter (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       sample_i,
  input  wire logic [1:0] orient_debounce_count_i,
  input  wire logic [1:0] xy_instant_i,
  input  wire logic [1:0] z_instant_i,
  output logic      [1:0] xy_filtered_o,
  output logic      [1:0] z_filtered_o,
  output logic            xy_change_o,
  output logic            z_change_o
);
  import aor_pkg::*;

  logic [1:0] cand_xy;
  logic [1:0] cand_z;
  logic [7:0] run_count;
  logic [7:0] need_count;
  logic [1:0] target_xy;
  logic       differs;
  logic       same_cand;
  logic       done;
  logic [7:0] next_run_count;

  assign need_count = (orient_debounce_count_i == 2'h0) ? ORIENT_COUNT_00 :
                      (orient_debounce_count_i == 2'h1) ? ORIENT_COUNT_01 :
                      (orient_debounce_count_i == 2'h2) ? ORIENT_COUNT_10 :
                                                          ORIENT_COUNT_11;
  // While tilted the XY part keeps its old value, so it cannot start a change.
  assign target_xy = z_instant_i[1] ? xy_filtered_o : xy_instant_i;
  assign differs   = {target_xy, z_instant_i} != {xy_filtered_o, z_filtered_o};
  assign same_cand = {target_xy, z_instant_i} == {cand_xy, cand_z};
  assign next_run_count = same_cand ? run_count + 8'h01 : 8'h01;
  assign done      = sample_i && differs && (next_run_count >= need_count);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cand_xy       <= ORIENT_RESET;
      cand_z        <= ORIENT_RESET;
      run_count     <= 8'h00;
      xy_filtered_o <= ORIENT_RESET;
      z_filtered_o  <= ORIENT_RESET;
      xy_change_o   <= 1'b0;
      z_change_o    <= 1'b0;
    end else begin
      xy_change_o <= 1'b0;
      z_change_o  <= 1'b0;
      if (sample_i) begin
        cand_xy <= target_xy;
        cand_z  <= z_instant_i;
        if (!differs || done) begin
          run_count <= 8'h00;
        end else begin
          run_count <= next_run_count;
        end
        if (done) begin
          xy_filtered_o <= target_xy;
          z_filtered_o  <= z_instant_i;
          xy_change_o   <= target_xy != xy_filtered_o;
          z_change_o    <= z_instant_i != z_filtered_o;
        end
      end
    end
  end
endmodule // aor_orient_filter

//--- tb/aor_readout_assertions.sv
`timescale 1ns/1ps
module aor_readout_checker
  import aor_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic       xfer_active_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       meas_done_i,
  input wire logic       calib_done_i,
  input wire logic       new_sample_flag_o,
  input wire logic       soft_reset_active_o,
  input wire logic       irq_pin_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  logic calib_seen;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || soft_reset_active_o) calib_seen <= 1'b0;
    else if (calib_done_i) calib_seen <= 1'b1;
  end

  a_status_upper_zero: assert property (
    reg_rd_i && reg_addr_i == ADDR_STATUS |=> reg_rdata_o[7:5] == 3'h0)
    else $error("status upper bits not zero");
  a_low_nibble_zero: assert property (
    reg_rd_i && (reg_addr_i == ADDR_X_LOW || reg_addr_i == ADDR_Y_LOW ||
    reg_addr_i == ADDR_Z_LOW) |=> reg_rdata_o[3:0] == 4'h0)
    else $error("low byte nibble not zero");
  a_irq_en_write_only: assert property (
    reg_rd_i && reg_addr_i == ADDR_IRQ_EN |=> reg_rdata_o == 8'h00)
    else $error("enable register readable");
  a_irq_drive_low: assert property (
    irq_pin_o == 1'b0)
    else $error("interrupt pin driven high");
  a_soft_reset_start: assert property (
    reg_wr_i && reg_addr_i == ADDR_SRC1 && reg_wdata_i[SOFT_RESET_BIT]
    |-> ##[1:2] soft_reset_active_o)
    else $error("soft reset not taken");
  a_soft_reset_hold: assert property (
    soft_reset_active_o && xfer_active_i && $past(xfer_active_i) |=> soft_reset_active_o)
    else $error("soft reset dropped during transfer");
  a_new_sample_set: assert property (
    meas_done_i && !xfer_active_i && !soft_reset_active_o && !$past(soft_reset_active_o)
    |-> ##3 new_sample_flag_o)
    else $error("new sample flag not set");
  a_calib_sticky: assert property (
    reg_rd_i && reg_addr_i == ADDR_STATUS && calib_seen && !soft_reset_active_o &&
    !$past(soft_reset_active_o) |=> reg_rdata_o[CALIB_LOADED_BIT])
    else $error("calibration flag not set");
endmodule // aor_readout_checker

bind aor_readout aor_readout_checker i_chk (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .xfer_active_i, .reg_rdata_o, .meas_done_i, .calib_done_i,
  .new_sample_flag_o, .soft_reset_active_o, .irq_pin_o);

//--- tb/aor_host_model.sv
`timescale 1ns/1ps
module aor_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic            xfer_active_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    xfer_active_o = 1'b0;
  end

  // --------------------------------------------------------------
  // One transfer; keep leaves the transfer open for a soft reset.
  // --------------------------------------------------------------
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                        input logic keep, output logic [7:0] rdata);
    @(negedge sys_clk_i);
    xfer_active_o = 1'b1;
    reg_addr_o = addr;
    reg_wdata_o = data;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~addr;
    reg_wdata_o = ~data;
    @(negedge sys_clk_i);
    rdata = reg_rdata_i;
    xfer_active_o = keep;
  endtask
endmodule // aor_host_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import aor_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic        xfer_active_i;
  logic [7:0]  reg_rdata_o;
  logic        meas_done_i = 1'b0;
  logic [11:0] x_accel_i = 12'h000;
  logic [11:0] y_accel_i = 12'h000;
  logic [11:0] z_accel_i = 12'h000;
  logic [7:0]  temp_i = 8'h00;
  logic        calib_done_i = 1'b0;
  logic [1:0]  orient_debounce_count_i = 2'h0;
  logic [7:0]  src0_clear_i = 8'h00;
  logic        new_sample_clear_i = 1'b0;
  logic [3:0]  shake_event_i = 4'h0;
  logic [1:0]  xy_orient_filtered_o;
  logic [1:0]  z_orient_filtered_o;
  logic        new_sample_flag_o;
  logic        soft_reset_active_o;
  logic        irq_pin_o;
  logic        irq_oe_n_o;
  logic [7:0]  q;
  logic [1:0]  exp_xy = 2'h0;
  logic [1:0]  exp_z = 2'h0;
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  aor_host_model i_host (.sys_clk_i, .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .xfer_active_o(xfer_active_i));
  aor_readout i_dut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .xfer_active_i, .reg_rdata_o, .meas_done_i, .x_accel_i, .y_accel_i, .z_accel_i, .temp_i,
    .calib_done_i, .orient_debounce_count_i, .shake_event_i, .src0_clear_i,
    .new_sample_clear_i, .xy_orient_filtered_o, .z_orient_filtered_o, .new_sample_flag_o,
    .soft_reset_active_o, .irq_pin_o, .irq_oe_n_o);

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] data;
    i_host.access(1'b0, addr, 8'h00, 1'b0, data);
    check(data, exp);
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge sys_clk_i);
      meas_done_i = 1'b1;
      @(negedge sys_clk_i);
      meas_done_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("unexpected at %0t: timeout", $time);
      stop_test();
    end
  end

  // --------------------------------------------------------------
  // Each count code flips between a flat and a tilted position.
  // --------------------------------------------------------------
  initial begin
    repeat (10) @(negedge sys_clk_i);
    rst_i = 1'b0;
    calib_done_i = 1'b1;
    for (int k = 0; k < 4; k++) begin
      orient_debounce_count_i = k[1:0];
      x_accel_i = k[0] ? 12'h000 : 12'h812;
      y_accel_i = k[0] ? 12'h000 : 12'h0a5;
      z_accel_i = k[0] ? 12'h400 : 12'hfc4;
      temp_i = 8'he6;
      i_host.access(1'b1, ADDR_IRQ_EN, k[0] ? 8'h00 : 8'h80, 1'b0, q);
      pulse((16 << k) - 1);
      check({4'h0, xy_orient_filtered_o, z_orient_filtered_o}, {4'h0, exp_xy, exp_z});
      exp_xy = XY_NEG_X;
      exp_z = k[0] ? 2'h2 : 2'h1;
      pulse(1);
      check({4'h0, xy_orient_filtered_o, z_orient_filtered_o}, {4'h0, exp_xy, exp_z});
      check({7'h0, irq_oe_n_o}, {7'h0, k[0]});
      src0_clear_i = 8'hc0;
      @(negedge sys_clk_i);
      src0_clear_i = 8'h00;
      repeat (3) @(negedge sys_clk_i);
      check({7'h0, irq_oe_n_o}, 8'h01);
      if (k == 0) begin
        rd(ADDR_X_HIGH, 8'h81);
        rd(ADDR_X_LOW, 8'h20);
        rd(ADDR_Y_HIGH, 8'h0a);
        rd(ADDR_Y_LOW, 8'h50);
        rd(ADDR_Z_HIGH, 8'hfc);
        rd(ADDR_Z_LOW, 8'h40);
        rd(ADDR_TEMP, 8'he6);
        rd(ADDR_STATUS, 8'h16);
        rd(ADDR_IRQ_EN, 8'h00);
        rd(8'h1f, 8'h00);
        rd(ADDR_SRC1, 8'h61);
        check({7'h0, new_sample_flag_o}, 8'h01);
        new_sample_clear_i = 1'b1;
        @(negedge sys_clk_i);
        new_sample_clear_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        check({7'h0, new_sample_flag_o}, 8'h00);
      end
      $display("filter test with count code %0d done", k);
    end
    // Only the +X shake source is enabled; a -X shake must not pull the pin.
    i_host.access(1'b1, ADDR_IRQ_EN, 8'h01, 1'b0, q);
    @(negedge sys_clk_i);
    shake_event_i = 4'h2;
    @(negedge sys_clk_i);
    shake_event_i = 4'h0;
    repeat (3) @(negedge sys_clk_i);
    check({7'h0, irq_oe_n_o}, 8'h01);
    @(negedge sys_clk_i);
    shake_event_i = 4'h1;
    @(negedge sys_clk_i);
    shake_event_i = 4'h0;
    repeat (3) @(negedge sys_clk_i);
    check({7'h0, irq_oe_n_o}, 8'h00);
    rd(ADDR_SRC0, 8'h03);
    $display("shake enable test done");
    i_host.access(1'b1, ADDR_SRC1, 8'h10, 1'b1, q);
    repeat (4) @(negedge sys_clk_i);
    check({7'h0, soft_reset_active_o}, 8'h01);
    rd(ADDR_Z_HIGH, 8'h00);
    repeat (3) @(negedge sys_clk_i);
    check({7'h0, soft_reset_active_o}, 8'h00);
    check({4'h0, xy_orient_filtered_o, z_orient_filtered_o}, 8'h00);
    check({7'h0, irq_oe_n_o}, 8'h01);
    rd(ADDR_Z_HIGH, 8'h00);
    $display("soft reset test done");
    stop_test();
  end
endmodule // tb_top
